// *** hw/amc_pkg.sv ***
// Purpose: shared constants and types for the amplifier control block
// Assumes: 250 MHz clock
// Notes:   start-up time is a parameter default of the top module
package amc_pkg;
    localparam int unsigned AMC_CLK_MHZ     = 250;
    // start-up settle time in microseconds (set by external capacitance)
    localparam int unsigned AMC_STARTUP_US  = 100;
    localparam int unsigned AMC_STARTUP_CYC = AMC_STARTUP_US * AMC_CLK_MHZ;
    localparam int unsigned AMC_CNT_W       = 32;
    localparam int unsigned AMC_SYNC_N      = 5;

    // bit positions of the synchronised input vector
    localparam int unsigned AMC_IX_MUTE  = 0;
    localparam int unsigned AMC_IX_SLEEP = 1;
    localparam int unsigned AMC_IX_OCL   = 2;
    localparam int unsigned AMC_IX_OCR   = 3;
    localparam int unsigned AMC_IX_OT    = 4;

    typedef enum logic [2:0] {
        AMC_ST_SLEEP = 3'h1,
        AMC_ST_START = 3'h2,
        AMC_ST_RUN   = 3'h4
    } amc_state_t;

    // one bridge-tied channel: positive and negative terminal
    typedef struct packed {
        logic pos;
        logic neg;
    } amc_btl_t;
endpackage

// *** hw/amc_sync.sv ***
// Purpose: two flip-flop synchroniser, one per bit
// Assumes: inputs asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module amc_sync #(
    parameter int unsigned N = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [N-1:0] async_in,
    output logic      [N-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= async_in[i];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_out[i] = sync_reg;
        end
    endgenerate
endmodule

// *** hw/amc_ctrl.sv ***
// Purpose: mute, sleep, start-up and fault warning control of a stereo
//          class-D amplifier
// Assumes: pwm streams and detector levels come from the analog side
// Notes:   outputs are registered, so pwm passes with one cycle of delay
//
// Summary of operation
// - mute high: all four output terminals held low, device muted.
// - mute low while running: modulated pulse stream drives all four terminals.
// - sleep high: circuits off, outputs muted, minimum power state.
// - in sleep the warning output is held low.
// - after sleep falls, run only after start-up settle interval.
// - warning output high when overcurrent or overheat is reported.
// - overcurrent in either channel's buffers raises a warning.
// - abnormal junction temperature raises a warning.
// - mute and sleep act on both channels together.
// - each channel drives positive and negative bridge terminals.
// - overcurrent warning latches until a sleep low-high-low cycle.
// - overheat warning follows the detector, cleared by sleep.
// - overcurrent detection is disabled while muted.
// - both detectors are disabled while asleep.
`timescale 1ns/1ps
module amc_ctrl
    import amc_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = AMC_STARTUP_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // control pins
    input  wire logic mute_in,
    input  wire logic sleep_in,
    // detectors and modulator
    input  wire logic left_overcurrent_in,
    input  wire logic right_overcurrent_in,
    input  wire logic overtemp_in,
    input  amc_pkg::amc_btl_t left_pwm_in,
    input  amc_pkg::amc_btl_t right_pwm_in,
    // outputs
    output logic left_pos_pwm_out,
    output logic left_neg_pwm_out,
    output logic right_pos_pwm_out,
    output logic right_neg_pwm_out,
    output logic fault_warning_out,
    output logic sleep_state_out
);
    import amc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic                  rst_meta_reg;
    logic                  rst_n_reg;
    logic [AMC_SYNC_N-1:0] raw_vec;
    logic [AMC_SYNC_N-1:0] syn_vec;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // sleep enters inverted so a cleared synchroniser reads as asleep;
    // a sleep pin high at reset must not trigger a false start-up
    assign raw_vec = {overtemp_in, right_overcurrent_in,
                      left_overcurrent_in, !sleep_in, mute_in};

    amc_sync #(.N(AMC_SYNC_N)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n_reg),
        .async_in (raw_vec),
        .sync_out (syn_vec)
    );

    wire mute_s  = syn_vec[AMC_IX_MUTE];
    wire sleep_s = !syn_vec[AMC_IX_SLEEP];
    wire oc_s    = syn_vec[AMC_IX_OCL] | syn_vec[AMC_IX_OCR];
    wire ot_s    = syn_vec[AMC_IX_OT];

    ////////////////////////////////////////////////////////////////////////
    // power state: comes up asleep until the start-up interval has run
    amc_state_t           state_reg;
    amc_state_t           state_next;
    logic [AMC_CNT_W-1:0] cnt_reg;
    logic [AMC_CNT_W-1:0] cnt_next;
    localparam logic [AMC_CNT_W-1:0] CNT_LAST = AMC_CNT_W'(STARTUP_CYC - 1);

    wire cnt_done = (cnt_reg == CNT_LAST);

    always_comb begin
        state_next = state_reg;
        cnt_next   = '0;
        case (state_reg)
            AMC_ST_SLEEP: begin
                if (!sleep_s) begin
                    state_next = AMC_ST_START;
                end
            end
            AMC_ST_START: begin
                cnt_next = cnt_reg + 1'b1;
                if (sleep_s) begin
                    state_next = AMC_ST_SLEEP;
                end else if (cnt_done) begin
                    state_next = AMC_ST_RUN;
                end
            end
            AMC_ST_RUN: begin
                if (sleep_s) begin
                    state_next = AMC_ST_SLEEP;
                end
            end
            default: begin
                state_next = AMC_ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= AMC_ST_SLEEP;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    wire running  = (state_reg == AMC_ST_RUN);
    wire asleep   = !running; // start-up counts as still shut down
    wire muted    = asleep | mute_s;

    ////////////////////////////////////////////////////////////////////////
    // overcurrent latch; cleared in the high phase of the low-high-low
    // sequence and held clear through start-up; set and clear never meet
    // because setting needs the run state
    logic oc_reg;
    wire  oc_detect = oc_s & running & !mute_s;
    wire  oc_next   = asleep ? 1'b0 : (oc_reg | oc_detect);

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            oc_reg <= 1'b0;
        end else begin
            oc_reg <= oc_next;
        end
    end

    // overheat is not latched: it follows the detector while awake
    wire ot_warn   = ot_s & running;
    wire warn_next = running & (oc_reg | ot_warn);

    ////////////////////////////////////////////////////////////////////////
    // output gating; the negative leg carries its own stream (bridge load)
    amc_btl_t left_q;
    amc_btl_t right_q;
    logic     warn_reg;
    wire amc_btl_t left_g  = muted ? amc_btl_t'('0) : left_pwm_in;
    wire amc_btl_t right_g = muted ? amc_btl_t'('0) : right_pwm_in;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            left_q   <= '0;
            right_q  <= '0;
            warn_reg <= 1'b0;
        end else begin
            left_q   <= left_g;
            right_q  <= right_g;
            warn_reg <= warn_next;
        end
    end

    assign left_pos_pwm_out  = left_q.pos;
    assign left_neg_pwm_out  = left_q.neg;
    assign right_pos_pwm_out = right_q.pos;
    assign right_neg_pwm_out = right_q.neg;
    assign fault_warning_out = warn_reg;
    assign sleep_state_out   = asleep;

    ////////////////////////////////////////////////////////////////////////
    sequence s_sleep_hold;
        sleep_s [*2];
    endsequence

    a_mute_low_out: assert property (@(posedge clk) disable iff (!rst_n_reg)
        muted |=> !left_pos_pwm_out && !left_neg_pwm_out
                  && !right_pos_pwm_out && !right_neg_pwm_out)
        else $error("outputs not low while muted");

    a_pwm_pass: assert property (@(posedge clk) disable iff (!rst_n_reg)
        !muted |=> left_pos_pwm_out == $past(left_pwm_in.pos)
                   && right_neg_pwm_out == $past(right_pwm_in.neg))
        else $error("pwm not passed while unmuted");

    a_sleep_state: assert property (@(posedge clk) disable iff (!rst_n_reg)
        s_sleep_hold |-> !running)
        else $error("running while sleep held");

    a_sleep_warn_low: assert property (@(posedge clk) disable iff (!rst_n_reg)
        asleep |=> !fault_warning_out)
        else $error("warning high in sleep");

    a_start_wait: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (state_reg == AMC_ST_START && !cnt_done) |=> !running)
        else $error("run before start-up done");

    a_warn_cause: assert property (@(posedge clk) disable iff (!rst_n_reg)
        running && (oc_reg || ot_s) |=> fault_warning_out)
        else $error("warning missing on fault");

    a_oc_latch: assert property (@(posedge clk) disable iff (!rst_n_reg)
        oc_reg && running && !sleep_s |=> oc_reg)
        else $error("overcurrent latch lost");

    a_oc_mute_off: assert property (@(posedge clk) disable iff (!rst_n_reg)
        !oc_reg && mute_s |=> !oc_reg)
        else $error("overcurrent set while muted");

    a_ot_follow: assert property (@(posedge clk) disable iff (!rst_n_reg)
        running && !ot_s && !oc_reg |=> !fault_warning_out)
        else $error("overheat warning latched");
endmodule

// *** testbench/amc_pwm_model.sv ***
// Purpose: modulator stand-in feeding both bridge channels
// Assumes: same clock as the control block
// Notes:   two duty cycles so a swapped channel shows up
`timescale 1ns/1ps
module amc_pwm_model
    import amc_pkg::*;
(
    // clock
    input  wire logic         clk,
    // modulated streams
    output amc_pkg::amc_btl_t left_pwm,
    output amc_pkg::amc_btl_t right_pwm
);
    logic [2:0] cnt_reg = 3'h0;
    // changes just after the edge, like every other driver here
    always @(posedge clk) begin
        #1;
        cnt_reg <= cnt_reg + 3'h1;
    end
    // negative terminal is the complement, never tied to ground
    assign left_pwm  = '{pos: cnt_reg < 3'h3,
                         neg: !(cnt_reg < 3'h3)};
    assign right_pwm = '{pos: cnt_reg < 3'h5,
                         neg: !(cnt_reg < 3'h5)};
endmodule

// *** testbench/test_amc_ctrl.sv ***
// Purpose: self-checking bench for the amplifier control block
// Assumes: start-up shortened to 8 cycles
// Notes:   outputs are judged against the stream one cycle earlier
`timescale 1ns/1ps
module test_amc_ctrl;
    import amc_pkg::*;
    localparam int unsigned ST = 8;
    logic       clk, reset_n, mute_in, sleep_in, oc_l, oc_r, hot;
    logic       lp, ln, rp, rn, warn, slp;
    amc_btl_t   pl, pr;
    logic [3:0] prev_pwm;
    int         fails, check_count;
    wire  [3:0] outs = {lp, ln, rp, rn};

    amc_ctrl #(.STARTUP_CYC(ST)) i_amc_ctrl (.clk(clk), .reset_n(reset_n),
        .mute_in(mute_in), .sleep_in(sleep_in), .left_overcurrent_in(oc_l),
        .right_overcurrent_in(oc_r), .overtemp_in(hot), .left_pwm_in(pl),
        .right_pwm_in(pr), .left_pos_pwm_out(lp), .left_neg_pwm_out(ln),
        .right_pos_pwm_out(rp), .right_neg_pwm_out(rn),
        .fault_warning_out(warn), .sleep_state_out(slp));
    amc_pwm_model i_amc_pwm_model (.clk(clk), .left_pwm(pl), .right_pwm(pr));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) prev_pwm <= {pl.pos, pl.neg, pr.pos, pr.neg};

    task automatic results();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(string name, logic [3:0] exp, logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_run();
        for (int k = 0; k < 40 && slp !== 1'b0; k++) tick(1);
        cmp("sleep_state", 4'h0, {3'h0, slp});
    endtask
    // start-up interval holds the outputs quiet, then pwm flows
    task automatic t_startup();
        sleep_in = 1'b0;
        tick(ST);
        cmp("sleep_state", 4'h1, {3'h0, slp});
        cmp("outs", 4'h0, outs);
        wait_run();
        tick(2);
        // a full pwm period, so a swapped channel cannot hide
        for (int i = 0; i < 8; i++) begin
            cmp("outs", prev_pwm, outs);
            cmp("bridge", 4'h3, {2'h0, lp ^ ln, rp ^ rn});
            tick(1);
        end
    endtask
    // mute gates both channels and blinds overcurrent detection
    task automatic t_mute();
        mute_in = 1'b1;
        tick(5);
        for (int i = 0; i < 4; i++) begin
            cmp("outs", 4'h0, outs);
            tick(1);
        end
        oc_l = 1'b1;
        tick(6);
        cmp("warn", 4'h0, {3'h0, warn});
        oc_l = 1'b0;
        mute_in = 1'b0;
        tick(5);
        cmp("outs", prev_pwm, outs);
    endtask
    // overcurrent latches on each channel until a sleep cycle
    task automatic t_oc_latch();
        for (int c = 0; c < 2; c++) begin
            if (c == 0) oc_l = 1'b1;
            else oc_r = 1'b1;
            tick(5);
            cmp("warn", 4'h1, {3'h0, warn});
            oc_l = 1'b0;
            oc_r = 1'b0;
            tick(10);
            cmp("warn", 4'h1, {3'h0, warn});
            sleep_in = 1'b1;
            tick(5);
            cmp("warn", 4'h0, {3'h0, warn});
            cmp("outs", 4'h0, outs);
            sleep_in = 1'b0;
            wait_run();
            cmp("warn", 4'h0, {3'h0, warn});
        end
    endtask
    // overheat follows the detector and is ignored while asleep
    task automatic t_hot();
        hot = 1'b1;
        tick(5);
        cmp("warn", 4'h1, {3'h0, warn});
        hot = 1'b0;
        tick(5);
        cmp("warn", 4'h0, {3'h0, warn});
        hot = 1'b1;
        tick(5);
        sleep_in = 1'b1;
        tick(5);
        cmp("warn", 4'h0, {3'h0, warn});
        oc_l = 1'b1;
        tick(6);
        cmp("warn", 4'h0, {3'h0, warn});
        cmp("sleep_state", 4'h1, {3'h0, slp});
        oc_l = 1'b0;
        hot = 1'b0;
        sleep_in = 1'b0;
        wait_run();
        // an overcurrent seen while asleep must not have been latched
        cmp("warn", 4'h0, {3'h0, warn});
    endtask

    initial begin
        #4000;
        fails++;
        results();
    end
    initial begin
        {reset_n, mute_in, oc_l, oc_r, hot} = 5'h00;
        sleep_in = 1'b1;
        tick(8);
        cmp("outs", 4'h0, outs);
        reset_n = 1'b1;
        tick(3);
        t_startup();
        t_mute();
        t_oc_latch();
        t_hot();
        results();
    end
endmodule
